// >>> rtl/ivp_unit.sv
// Interrupt vector address generation, priority resolution and vector fetch
`timescale 1ns/1ps
module ivp_unit
  import ivp_pkg::*;
(
  input  wire logic        ref_clk_in,          // CPU clock, 10 MHz
  input  wire logic        nrst_in,             // Asynchronous reset, active low
  input  wire logic [31:0] hw_req_in,           // Hardware request lines, one per vector
  input  wire logic        ack_in,              // CPU acknowledges the offered request
  input  wire logic        sw_int_in,           // Software interrupt strobe
  input  wire logic [4:0]  sw_num_in,           // Software interrupt vector number
  input  wire logic [15:0] main_vector_page_pointer_in, // Main vector page
  input  wire logic [15:0] high_vector_page_pointer_in, // High vector page
  input  wire logic [7:0]  mem_data_in,         // Program byte read data
  input  wire logic        mem_valid_in,        // Program byte read data valid
  output logic             mem_req_out,         // Program byte read request
  output logic [23:0]      mem_addr_out,        // Program byte address
  output logic             req_valid_out,       // A hardware request is offered
  output logic [4:0]       req_num_out,         // Vector number offered
  output logic             busy_out,            // Vector fetch in progress
  output logic [4:0]       active_num_out,      // Vector being fetched
  output logic             isr_start_out,       // Start execution at isr_addr_out
  output logic [23:0]      isr_addr_out,        // Service routine byte address
  output logic             stack_mode_valid_out, // Stack mode byte updated
  output logic [7:0]       stack_mode_out       // Stack mode setting from reset vector
);

  // Vector number to 24-bit vector byte address
  function automatic logic [23:0] vec_addr(input logic [4:0]  num,
                                           input logic [15:0] main_pg,
                                           input logic [15:0] high_pg);
    logic [15:0] pg;
    pg = main_pg;
    if (num >= IVP_HIGH_PAGE_FIRST && num <= IVP_HIGH_PAGE_LAST) begin
      pg = high_pg;
    end
    return {pg, num, 3'h0};
  endfunction : vec_addr

  // Request input synchroniser and edge detector
  logic [31:0] req_meta_r;
  logic [31:0] req_sync_r;
  logic [31:0] req_prev_r;
  logic [31:0] req_meta_nxt;
  logic [31:0] req_sync_nxt;
  logic [31:0] req_prev_nxt;
  logic [31:0] req_rise;

  // Plain shift, no logic may sit between the two synchroniser stages
  always_comb begin
    req_meta_nxt = hw_req_in;
    req_sync_nxt = req_meta_r;
    req_prev_nxt = req_sync_r;
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      req_meta_r <= 32'h0000_0000;
      req_sync_r <= 32'h0000_0000;
      req_prev_r <= 32'h0000_0000;
    end else begin
      req_meta_r <= req_meta_nxt;
      req_sync_r <= req_sync_nxt;
      req_prev_r <= req_prev_nxt;
    end
  end

  // Sources without a hardware path are dropped at the door
  assign req_rise = req_sync_r & ~req_prev_r & IVP_HW_CAPABLE_MASK;

  // Priority resolver
  ivp_arb_if arb_bus ();

  ivp_arbiter u_arbiter (
    .arb_io (arb_bus.arb)
  );

  // Pending flags and the offered request
  logic [31:0] pend_r;
  logic [31:0] pend_nxt;
  logic        req_valid_r;
  logic        req_valid_nxt;
  logic [4:0]  req_num_r;
  logic [4:0]  req_num_nxt;

  // Sequencer
  ivp_state_t  state_r;
  ivp_state_t  state_nxt;
  logic [4:0]  active_r;
  logic [4:0]  active_nxt;
  logic [2:0]  byte_idx_r;
  logic [2:0]  byte_idx_nxt;
  logic        mem_req_r;
  logic        mem_req_nxt;
  logic [23:0] mem_addr_r;
  logic [23:0] mem_addr_nxt;
  logic [23:0] target_r;
  logic [23:0] target_nxt;
  logic        isr_start_r;
  logic        isr_start_nxt;
  logic [23:0] isr_addr_r;
  logic [23:0] isr_addr_nxt;
  logic        stack_valid_r;
  logic        stack_valid_nxt;
  logic [7:0]  stack_mode_r;
  logic [7:0]  stack_mode_nxt;
  logic        busy_r;
  logic        busy_nxt;

  logic        take_hw;
  logic        take_sw;

  assign arb_bus.pend = pend_r;

  // Acknowledge only counts while the same winner is on offer and we are idle
  assign take_hw = (state_r == IVP_ST_IDLE) && req_valid_r && ack_in;
  // Software entry is immediate from idle, but a hardware acknowledge in the same cycle wins; any vector number is legal from software
  assign take_sw = (state_r == IVP_ST_IDLE) && sw_int_in && !take_hw;

  always_comb begin
    pend_nxt = pend_r;
    if (take_hw) begin
      pend_nxt[req_num_r] = 1'b0;
    end
    // A new edge wins over the clear in the same cycle
    pend_nxt      = pend_nxt | req_rise;
    req_valid_nxt = arb_bus.found;
    req_num_nxt   = arb_bus.num;
    if (take_hw) begin
      // Hide the served request for one cycle so it is not offered twice
      req_valid_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pend_r      <= 32'h0000_0000;
      req_valid_r <= 1'b0;
      req_num_r   <= IVP_RESET_ENTRY_VECTOR;
    end else begin
      pend_r      <= pend_nxt;
      req_valid_r <= req_valid_nxt;
      req_num_r   <= req_num_nxt;
    end
  end

  always_comb begin
    state_nxt       = state_r;
    active_nxt      = active_r;
    byte_idx_nxt    = byte_idx_r;
    mem_req_nxt     = mem_req_r;
    mem_addr_nxt    = mem_addr_r;
    target_nxt      = target_r;
    isr_start_nxt   = 1'b0;
    isr_addr_nxt    = isr_addr_r;
    stack_valid_nxt = 1'b0;
    stack_mode_nxt  = stack_mode_r;
    unique case (state_r)
      IVP_ST_IDLE: begin
        if (take_hw || take_sw) begin
          active_nxt   = take_hw ? req_num_r : sw_num_in;
          mem_addr_nxt = vec_addr(active_nxt, main_vector_page_pointer_in,
                                  high_vector_page_pointer_in);
          byte_idx_nxt = 3'h0;
          mem_req_nxt  = 1'b1;
          state_nxt    = IVP_ST_FETCH;
        end
      end
      IVP_ST_FETCH: begin
        if (mem_valid_in) begin
          unique case (byte_idx_r)
            IVP_BYTE_STACK_MODE: begin
              if (active_r == IVP_RESET_ENTRY_VECTOR) begin
                stack_mode_nxt  = mem_data_in;
                stack_valid_nxt = 1'b1;
              end
              // Other vectors: byte 0 is dropped
            end
            IVP_BYTE_ADDR_HI: begin
              target_nxt[23:16] = mem_data_in;
            end
            IVP_BYTE_ADDR_MID: begin
              target_nxt[15:8] = mem_data_in;
            end
            IVP_BYTE_ADDR_LO: begin
              target_nxt[7:0] = mem_data_in;
            end
            default: begin
              // Padding bytes are read to complete the block and discarded
            end
          endcase
          // All eight bytes are read before the routine is entered
          if (byte_idx_r == IVP_BYTE_LAST) begin
            mem_req_nxt = 1'b0;
            state_nxt   = IVP_ST_LAUNCH;
          end else begin
            byte_idx_nxt = byte_idx_r + 3'h1;
            mem_addr_nxt = mem_addr_r + 24'h00_0001;
          end
        end
      end
      IVP_ST_LAUNCH: begin
        isr_addr_nxt  = target_r;
        isr_start_nxt = 1'b1;
        state_nxt     = IVP_ST_IDLE;
      end
      default: begin
        state_nxt   = IVP_ST_IDLE;
        mem_req_nxt = 1'b0;
      end
    endcase
    // Kept in a flop of its own so the output carries no decode glitches
    busy_nxt = (state_nxt != IVP_ST_IDLE);
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_r       <= IVP_ST_IDLE;
      active_r      <= IVP_RESET_ENTRY_VECTOR;
      byte_idx_r    <= 3'h0;
      mem_req_r     <= 1'b0;
      mem_addr_r    <= IVP_ADDR_RST;
      target_r      <= IVP_ADDR_RST;
      isr_start_r   <= 1'b0;
      isr_addr_r    <= IVP_ADDR_RST;
      stack_valid_r <= 1'b0;
      stack_mode_r  <= IVP_STACK_MODE_RST;
      busy_r        <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      active_r      <= active_nxt;
      byte_idx_r    <= byte_idx_nxt;
      mem_req_r     <= mem_req_nxt;
      mem_addr_r    <= mem_addr_nxt;
      target_r      <= target_nxt;
      isr_start_r   <= isr_start_nxt;
      isr_addr_r    <= isr_addr_nxt;
      stack_valid_r <= stack_valid_nxt;
      stack_mode_r  <= stack_mode_nxt;
      busy_r        <= busy_nxt;
    end
  end

  assign mem_req_out          = mem_req_r;
  assign mem_addr_out         = mem_addr_r;
  assign req_valid_out        = req_valid_r;
  assign req_num_out          = req_num_r;
  assign busy_out             = busy_r;
  assign active_num_out       = active_r;
  assign isr_start_out        = isr_start_r;
  assign isr_addr_out         = isr_addr_r;
  assign stack_mode_valid_out = stack_valid_r;
  assign stack_mode_out       = stack_mode_r;

endmodule : ivp_unit

// >>> include/ivp_pkg.sv
// Constants, types and tables for the interrupt vector and priority unit
package ivp_pkg;

  localparam int unsigned IVP_NUM_VECTORS   = 32;
  localparam int unsigned IVP_NUM_W         = 5;
  localparam int unsigned IVP_ADDR_W        = 24;
  localparam int unsigned IVP_PAGE_W        = 16;
  localparam int unsigned IVP_BYTE_W        = 8;
  localparam int unsigned IVP_VEC_BYTES     = 8;
  localparam int unsigned IVP_BYTE_IDX_W    = 3;
  localparam int unsigned IVP_NUM_HW_RANKS  = 28;

  // Byte positions inside one vector
  localparam logic [2:0] IVP_BYTE_STACK_MODE = 3'h0;
  localparam logic [2:0] IVP_BYTE_ADDR_HI    = 3'h1;
  localparam logic [2:0] IVP_BYTE_ADDR_MID   = 3'h2;
  localparam logic [2:0] IVP_BYTE_ADDR_LO    = 3'h3;
  localparam logic [2:0] IVP_BYTE_LAST       = 3'h7;

  // Vectors of note
  localparam logic [4:0] IVP_RESET_ENTRY_VECTOR     = 5'h00;
  localparam logic [4:0] IVP_NONMASKABLE_VECTOR     = 5'h01;
  localparam logic [4:0] IVP_HIGH_PAGE_FIRST        = 5'h10;
  localparam logic [4:0] IVP_HIGH_PAGE_LAST         = 5'h17;
  localparam logic [4:0] IVP_BUS_FAULT_VECTOR       = 5'h18;
  localparam logic [4:0] IVP_DATALOG_VECTOR         = 5'h19;
  localparam logic [4:0] IVP_OS_SERVICE_VECTOR      = 5'h1a;
  localparam logic [4:0] IVP_EMULATION_VECTOR       = 5'h1d;
  localparam logic [4:0] IVP_SOFTWARE_ONLY_VECTOR_A = 5'h1e;
  localparam logic [4:0] IVP_SOFTWARE_ONLY_VECTOR_B = 5'h1f;

  // Vectors with a hardware source: all but 27, 28, 30 and 31
  localparam logic [31:0] IVP_HW_CAPABLE_MASK = 32'h27ff_ffff;

  // Reset values
  localparam logic [23:0] IVP_ADDR_RST       = 24'h00_0000;
  localparam logic [7:0]  IVP_STACK_MODE_RST = 8'h00;

  // Hardware ranking, index 0 is the best
  localparam logic [4:0] IVP_RANK_ORDER [0:IVP_NUM_HW_RANKS-1] = '{
    5'h00, 5'h1d, 5'h01, 5'h18, 5'h02, 5'h10, 5'h03, 5'h04, 5'h05, 5'h11,
    5'h06, 5'h07, 5'h08, 5'h12, 5'h09, 5'h0a, 5'h0b, 5'h13, 5'h0c, 5'h0d,
    5'h14, 5'h15, 5'h0e, 5'h0f, 5'h16, 5'h17, 5'h19, 5'h1a
  };

  // Sequencer states, Gray coded along idle -> fetch -> launch
  typedef enum logic [1:0] {
    IVP_ST_IDLE   = 2'b00,
    IVP_ST_FETCH  = 2'b01,
    IVP_ST_LAUNCH = 2'b11
  } ivp_state_t;

endpackage : ivp_pkg

// >>> include/ivp_arb_if.sv
// Carrier between the core and the priority resolver
`timescale 1ns/1ps
interface ivp_arb_if;
  logic [31:0] pend;
  logic        found;
  logic [4:0]  num;

  modport core (output pend, input found, input num);
  modport arb  (input pend, output found, output num);
endinterface : ivp_arb_if

// >>> rtl/ivp_arbiter.sv
// Fixed-priority resolver for pending hardware requests
`timescale 1ns/1ps
module ivp_arbiter
  import ivp_pkg::*;
(
  ivp_arb_if.arb arb_io // Pending set in, winner out
);

  logic [31:0] hw_pend;
  logic        found_c;
  logic [4:0]  num_c;

  // Reserved and software-only vectors can never win
  assign hw_pend = arb_io.pend & IVP_HW_CAPABLE_MASK;

  // Walk from worst to best so the best pending rank is the last to write
  always_comb begin
    found_c = 1'b0;
    num_c   = IVP_RESET_ENTRY_VECTOR;
    for (int i = IVP_NUM_HW_RANKS - 1; i >= 0; i--) begin
      if (hw_pend[IVP_RANK_ORDER[i]]) begin
        found_c = 1'b1;
        num_c   = IVP_RANK_ORDER[i];
      end
    end
  end

  assign arb_io.found = found_c;
  assign arb_io.num   = num_c;

endmodule : ivp_arbiter

// >>> testbench/ivp_unit_asserts.sv
// Port-level checks for the vector unit
`timescale 1ns/1ps
module ivp_unit_asserts
  import ivp_pkg::*;
(
  input wire logic        ref_clk_in,                  // Clock
  input wire logic        nrst_in,                     // Reset, active low
  input wire logic [31:0] hw_req_in,                   // Hardware requests
  input wire logic        ack_in,                      // Acknowledge
  input wire logic        sw_int_in,                   // Software strobe
  input wire logic [4:0]  sw_num_in,                   // Software number
  input wire logic [15:0] main_vector_page_pointer_in, // Main page
  input wire logic [15:0] high_vector_page_pointer_in, // High page
  input wire logic [7:0]  mem_data_in,                 // Read data
  input wire logic        mem_valid_in,                // Read valid
  input wire logic        mem_req_out,                 // Read request
  input wire logic [23:0] mem_addr_out,                // Read address
  input wire logic        req_valid_out,               // Offer valid
  input wire logic [4:0]  req_num_out,                 // Offer number
  input wire logic        busy_out,                    // Fetching
  input wire logic [4:0]  active_num_out,              // Vector fetched
  input wire logic        isr_start_out,               // Start pulse
  input wire logic [23:0] isr_addr_out,                // Routine address
  input wire logic        stack_mode_valid_out,        // Stack byte pulse
  input wire logic [7:0]  stack_mode_out               // Stack byte
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_last_byte;
    mem_req_out && mem_valid_in && (mem_addr_out[2:0] == 3'h7);
  endsequence
  sequence s_launch;
    !mem_req_out ##1 (isr_start_out && !busy_out);
  endsequence
  chk_launch_after_last: assert property (s_last_byte |=> s_launch)
    else $error("launch did not follow the last vector byte");
  chk_byte_step: assert property (mem_req_out && mem_valid_in && mem_addr_out[2:0] != 3'h7
    |=> mem_req_out && mem_addr_out == $past(mem_addr_out) + 24'h1)
    else $error("byte address did not step");
  chk_req_hold: assert property (mem_req_out && !mem_valid_in
    |=> mem_req_out && $stable(mem_addr_out))
    else $error("read request dropped while waiting");
  chk_vector_addr: assert property ($rose(mem_req_out) |->
    mem_addr_out == {(active_num_out inside {[16:23]}) ? high_vector_page_pointer_in
    : main_vector_page_pointer_in, active_num_out, 3'h0})
    else $error("vector address wrong");
  chk_ack_take: assert property (!busy_out && req_valid_out && ack_in
    |=> mem_req_out && active_num_out == $past(req_num_out))
    else $error("acknowledged request not fetched");
  chk_sw_take: assert property (!busy_out && sw_int_in && !(req_valid_out && ack_in)
    |=> mem_req_out && active_num_out == $past(sw_num_in))
    else $error("software request not fetched");
  chk_hw_source: assert property (req_valid_out
    |-> IVP_HW_CAPABLE_MASK[req_num_out])
    else $error("offer of a vector with no hardware source");
  chk_stack_grab: assert property (mem_req_out && mem_valid_in
    && mem_addr_out[2:0] == 3'h0 && active_num_out == 5'h00
    |=> stack_mode_valid_out && stack_mode_out == $past(mem_data_in))
    else $error("stack byte not captured");
  chk_stack_only: assert property (stack_mode_valid_out |-> active_num_out == 5'h00)
    else $error("stack byte taken from another vector");
endmodule : ivp_unit_asserts
bind ivp_unit ivp_unit_asserts u_chk (.*);

// >>> testbench/ivp_mem_model.sv
// Program memory holding the vectors, answers each byte read
`timescale 1ns/1ps
module ivp_mem_model #(
  parameter logic [7:0] NOP_BYTE = 8'h20 // No-operation encoding, plain default
) (
  input  wire logic        ref_clk_in,    // Clock
  input  wire logic        nrst_in,       // Reset, active low
  input  wire logic        slow_in,       // Answer every other cycle
  input  wire logic        mem_req_in,    // Read request
  input  wire logic [23:0] mem_addr_in,   // Read address
  output logic             mem_valid_out, // Read valid
  output logic [7:0]       mem_data_out   // Read data
);
  logic       skip_r;
  logic [7:0] byte_val;
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) skip_r <= 1'b0;
    else skip_r <= slow_in & ~skip_r;
  end
  // Bytes 0..3 follow the address so a wrong byte order shows up in the routine address
  assign byte_val = (mem_addr_in[2:0] > 3'h3) ? NOP_BYTE
                  : (mem_addr_in[7:0] ^ 8'ha5);
  assign mem_valid_out = mem_req_in & ~skip_r;
  // Data is scrambled while not valid, so a stale byte is never mistaken for a good one
  assign mem_data_out = mem_valid_out ? byte_val : ~byte_val;
endmodule : ivp_mem_model

// >>> testbench/tb.sv
// Self-checking bench for the vector unit
`timescale 1ns/1ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
  $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb;
  import ivp_pkg::*;
  typedef struct packed { logic [4:0] num; logic [7:0] lo; logic hi; } ivp_row_t;
  localparam logic [15:0] MAIN_PG = 16'h1234;
  localparam logic [15:0] HIGH_PG = 16'h5678;
  localparam ivp_row_t ROWS [0:9] = '{'{5'h00, 8'h00, 1'b0}, '{5'h01, 8'h08, 1'b0},
    '{5'h0f, 8'h78, 1'b0}, '{5'h10, 8'h80, 1'b1}, '{5'h17, 8'hb8, 1'b1}, '{5'h18, 8'hc0, 1'b0},
    '{5'h1a, 8'hd0, 1'b0}, '{5'h1b, 8'hd8, 1'b0}, '{5'h1e, 8'hf0, 1'b0}, '{5'h1f, 8'hf8, 1'b0}};
  localparam logic [4:0] HW_ORDER [0:5] = '{5'h00, 5'h1d, 5'h01, 5'h05, 5'h17, 5'h1a};
  logic        ref_clk_in, nrst_in, ack_in, sw_int_in, slow, mem_valid_in, mem_req_out;
  logic        req_valid_out, busy_out, isr_start_out, stack_mode_valid_out;
  logic [4:0]  sw_num_in, req_num_out, active_num_out;
  logic [7:0]  mem_data_in, stack_mode_out;
  logic [23:0] mem_addr_out, isr_addr_out;
  logic [31:0] hw_req_in;
  logic [15:0] main_pg, high_pg;
  logic [23:0] exp_addr;
  int          failures, cmp_count, cycles, n;
  ivp_unit dut (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .hw_req_in(hw_req_in),
    .ack_in(ack_in), .sw_int_in(sw_int_in), .sw_num_in(sw_num_in),
    .main_vector_page_pointer_in(main_pg), .high_vector_page_pointer_in(high_pg),
    .mem_data_in(mem_data_in), .mem_valid_in(mem_valid_in), .mem_req_out(mem_req_out),
    .mem_addr_out(mem_addr_out), .req_valid_out(req_valid_out), .req_num_out(req_num_out),
    .busy_out(busy_out), .active_num_out(active_num_out), .isr_start_out(isr_start_out),
    .isr_addr_out(isr_addr_out), .stack_mode_valid_out(stack_mode_valid_out),
    .stack_mode_out(stack_mode_out));
  ivp_mem_model u_mem (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .slow_in(slow),
    .mem_req_in(mem_req_out), .mem_addr_in(mem_addr_out), .mem_valid_out(mem_valid_in),
    .mem_data_out(mem_data_in));
  initial begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end
  task automatic give_verdict();
    if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  task automatic wait_start(input logic [7:0] lo);
    n = 0;
    while (isr_start_out !== 1'b1 && n < 100) begin
      @(negedge ref_clk_in);
      n++;
    end
    `CHK(isr_start_out, 1'b1)
    `CHK(isr_addr_out, ({lo + 8'h1, lo + 8'h2, lo + 8'h3} ^ 24'ha5a5a5))
    `CHK(busy_out, 1'b0)
    @(negedge ref_clk_in);
    `CHK(isr_start_out, 1'b0)
  endtask : wait_start
  task automatic wait_offer();
    n = 0;
    while (req_valid_out !== 1'b1 && n < 50) begin
      @(negedge ref_clk_in);
      n++;
    end
  endtask : wait_offer
  // Cut a hang short well above the expected few hundred cycles
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end
  initial begin
    nrst_in = 1'b0; hw_req_in = 32'h0; ack_in = 1'b0; sw_int_in = 1'b0; sw_num_in = 5'h00;
    slow = 1'b0;
    main_pg = MAIN_PG;
    high_pg = HIGH_PG;
    repeat (5) @(negedge ref_clk_in);
    `CHK(mem_req_out, 1'b0)
    `CHK(isr_addr_out, IVP_ADDR_RST)
    `CHK(stack_mode_out, IVP_STACK_MODE_RST)
    nrst_in = 1'b1;
    @(negedge ref_clk_in);
    foreach (ROWS[i]) begin
      sw_int_in = 1'b1;
      sw_num_in = ROWS[i].num;
      @(negedge ref_clk_in);
      sw_int_in = 1'b0;
      `CHK(mem_addr_out, ({(ROWS[i].hi ? HIGH_PG : MAIN_PG), ROWS[i].lo}))
      `CHK(active_num_out, ROWS[i].num)
      `CHK(busy_out, 1'b1)
      wait_start(ROWS[i].lo);
      `CHK(stack_mode_out, 8'ha5)
    end
    // Many requests at once, reserved and software-only bits too, with a stalling memory
    slow = 1'b1;
    main_pg = 16'h0a0b;
    high_pg = 16'hc0d0;
    hw_req_in = 32'hfc80_0023;
    for (int k = 0; k < 6; k++) begin
      wait_offer();
      `CHK(req_num_out, HW_ORDER[k])
      ack_in = 1'b1;
      sw_int_in = (k == 0);
      sw_num_in = 5'h03;
      @(negedge ref_clk_in);
      ack_in = 1'b0;
      `CHK(active_num_out, HW_ORDER[k])
      `CHK(req_valid_out, 1'b0)
      exp_addr = {(HW_ORDER[k] inside {[16:23]}) ? high_pg : main_pg, HW_ORDER[k], 3'h0};
      `CHK(mem_addr_out, exp_addr)
      @(negedge ref_clk_in);
      sw_int_in = 1'b0;
      wait_start({HW_ORDER[k], 3'h0});
    end
    repeat (10) @(negedge ref_clk_in);
    `CHK(req_valid_out, 1'b0)
    hw_req_in = 32'h0;
    nrst_in = 1'b0;
    @(negedge ref_clk_in);
    `CHK(isr_addr_out, IVP_ADDR_RST)
    `CHK(stack_mode_out, IVP_STACK_MODE_RST)
    `CHK(busy_out, 1'b0)
    nrst_in = 1'b1;
    repeat (3) @(negedge ref_clk_in);
    `CHK(req_valid_out, 1'b0)
    // A fresh request after the mid-run reset, on a vector whose byte 0 must be ignored
    hw_req_in = 32'h0100_0000;
    wait_offer();
    `CHK(req_num_out, 5'h18)
    ack_in = 1'b1;
    @(negedge ref_clk_in);
    ack_in = 1'b0;
    `CHK(active_num_out, 5'h18)
    wait_start(8'hc0);
    `CHK(stack_mode_out, IVP_STACK_MODE_RST)
    give_verdict();
  end
endmodule : tb
